// ---- inc/dpll_ctrl_pkg.sv ----
// Shared constants and types for the DPLL mode and state controller
package dpll_ctrl_pkg;

    // Operating states
    typedef enum logic [2:0] {
        state_freerun    = 3'b000,
        state_normal     = 3'b001,
        state_auto_hold  = 3'b010,
        state_hold       = 3'b011,
        state_short_hold = 3'b100
    } op_state_type;

    // Mode-select pin codes
    localparam logic [1:0] MODE_NORMAL   = 2'h0;
    localparam logic [1:0] MODE_HOLD     = 2'h1;
    localparam logic [1:0] MODE_FREERUN  = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;

    // Reference frequency codes
    typedef enum logic [1:0] {
        freq_reserved = 2'b00,
        freq_8k       = 2'b01,
        freq_1544k    = 2'b10,
        freq_2048k    = 2'b11
    } ref_freq_type;

    // Timing figures
    localparam int CLK_PERIOD_NS    = 10;
    localparam int SAVE_PERIOD_MS   = 30;
    localparam int MON_PERIOD_MS    = 2000;
    localparam int LOCK_MAX_MS      = 30000;
    localparam int QUICK_LOCK_MS    = 500;
    localparam int SAVE_CYCLES      = SAVE_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int MON_CYCLES       = MON_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    // Thirty seconds of cycles overflows a 32-bit signed int, so this one is wider
    localparam longint LOCK_MAX_CYCLES = longint'(LOCK_MAX_MS) * 1000000 / CLK_PERIOD_NS;
    localparam int QUICK_LOCK_CYC   = QUICK_LOCK_MS * 1000000 / CLK_PERIOD_NS;

    // Reset values
    localparam logic RST_STEP_FIX = 1'b0;

    // Status outputs grouped
    typedef struct packed {
        logic normal;
        logic hold;
        logic freerun;
    } status_type;

endpackage

// ---- hw/dpll_mode_state_control.sv ----
// Mode and state controller of a dual-reference DPLL
`timescale 1ns/10ps

module dpll_mode_state_control
    import dpll_ctrl_pkg::*;
#(
    parameter int WORD_W      = 32,
    parameter int SAVE_CYC    = SAVE_CYCLES,
    parameter int MON_CYC     = MON_CYCLES,
    parameter longint LOCK_CYC = LOCK_MAX_CYCLES,
    parameter int QLOCK_CYC   = QUICK_LOCK_CYC
) (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    // Mode and control pins
    input  wire logic              i_op_state_pick_hi,
    input  wire logic              i_op_state_pick_lo,
    input  wire logic              i_phase_step_fix_on,
    input  wire logic              i_quick_lock_req,
    input  wire logic              i_ref_freq_pick_hi,
    input  wire logic              i_ref_freq_pick_lo,
    input  wire logic              i_ref_select,
    // Frame pulse and references
    input  wire logic              i_frame_pulse_8k,
    input  wire logic              i_ref_in_a,
    input  wire logic              i_ref_in_b,
    // Loop status from datapath
    input  wire logic              i_ref_invalid,
    input  wire logic              i_ref_off_12ppm,
    input  wire logic              i_loop_locked,
    input  wire logic [WORD_W-1:0] i_freq_word,
    // Outputs
    output logic                   o_normal,
    output logic                   o_hold,
    output logic                   o_freerun,
    output logic                   o_phase_step_fix_en,
    output logic                   o_quick_lock_active,
    output logic                   o_use_master_osc,
    output logic                   o_ref_sel,
    output logic                   o_ref_fall,
    output logic [1:0]             o_ref_freq,
    output logic                   o_ref_freq_valid,
    output logic                   o_ref_off_freq_flag,
    output logic [WORD_W-1:0]      o_hold_word,
    output logic                   o_lock_timeout,
    output logic [2:0]             o_state
);

    initial begin
        if (WORD_W < 1 || SAVE_CYC < 1 || MON_CYC < 1 || LOCK_CYC < 1 || QLOCK_CYC < 1
            || LOCK_CYC > 64'hFFFFFFFF) begin
            $error("dpll_mode_state_control: bad parameter");
        end
    end

    // Registers
    op_state_type      state_q, state_d;
    logic              frame_q;
    logic              sel_q;
    logic              sel_seen_q;
    logic              sel_trans_q;
    logic              fix_q, fix_d;
    logic [1:0]        freq_q;
    logic              ref_a_q, ref_b_q;
    logic              fall_q;
    logic              mon_q;
    logic [31:0]       save_cnt_q;
    logic [31:0]       mon_cnt_q;
    logic [31:0]       lock_cnt_q;
    logic              slot_q;
    logic [WORD_W-1:0] slot0_q, slot1_q;
    logic [WORD_W-1:0] hold_word_q;
    logic              ref_sel_q;

    // Decode
    wire [1:0] mode_pins  = {i_op_state_pick_hi, i_op_state_pick_lo};
    wire       frame_rise = i_frame_pulse_8k & ~frame_q;
    wire       sel_change = sel_seen_q & (i_ref_select != sel_q);
    wire       trans_any  = sel_trans_q | sel_change;
    wire       save_tick  = (save_cnt_q == 32'(SAVE_CYC - 1));
    wire       mon_tick   = (mon_cnt_q == 32'(MON_CYC - 1));
    wire       in_normal  = (state_q == state_normal);
    wire [31:0] lock_limit = i_quick_lock_req ? 32'(QLOCK_CYC) : 32'(LOCK_CYC);
    wire [WORD_W-1:0] older_word = slot_q ? slot1_q : slot0_q;
    wire       cur_ref    = ref_sel_q ? i_ref_in_b : i_ref_in_a;
    wire       prev_ref   = ref_sel_q ? ref_b_q : ref_a_q;

    // Next state
    always_comb begin
        state_d = state_q;
        if (frame_rise) begin
            case (state_q)
                state_normal: begin
                    if (i_ref_invalid) begin
                        state_d = state_auto_hold;
                    end else if (trans_any) begin
                        state_d = state_short_hold;
                    end else if (mode_pins == MODE_HOLD) begin
                        state_d = state_hold;
                    end else if (mode_pins == MODE_FREERUN) begin
                        state_d = state_freerun;
                    end
                end
                state_auto_hold: begin
                    if (trans_any) begin
                        state_d = state_short_hold;
                    end else if (!i_ref_invalid) begin
                        state_d = state_normal;
                    end
                end
                state_short_hold: begin
                    if (!trans_any) begin
                        state_d = state_normal;
                    end
                end
                state_hold: begin
                    if (mode_pins == MODE_NORMAL) begin
                        state_d = state_normal;
                    end else if (mode_pins == MODE_FREERUN) begin
                        state_d = state_freerun;
                    end
                end
                state_freerun: begin
                    if (mode_pins == MODE_NORMAL) begin
                        state_d = state_normal;
                    end else if (mode_pins == MODE_HOLD) begin
                        state_d = state_hold;
                    end
                end
                default: begin
                    state_d = state_freerun;
                end
            endcase
        end
    end

    // Phase-step correction enable
    always_comb begin
        fix_d = fix_q;
        if (state_d != state_q) begin
            // Only a return from a holdover state may keep correction on
            if (state_d == state_normal && state_q != state_freerun) begin
                fix_d = i_phase_step_fix_on;
            end else begin
                fix_d = 1'b0;
            end
        end else if (in_normal) begin
            fix_d = i_phase_step_fix_on;
        end
    end

    // State, select tracking and correction enable
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q     <= state_freerun;
            frame_q     <= 1'b0;
            sel_q       <= 1'b0;
            sel_seen_q  <= 1'b0;
            sel_trans_q <= 1'b0;
            fix_q       <= RST_STEP_FIX;
            ref_sel_q   <= 1'b0;
        end else begin
            state_q    <= state_d;
            frame_q    <= i_frame_pulse_8k;
            sel_q      <= i_ref_select;
            sel_seen_q <= 1'b1;
            fix_q      <= fix_d;
            // Transient held until the next frame edge so it is not missed
            if (sel_change) begin
                sel_trans_q <= 1'b1;
            end else if (frame_rise) begin
                sel_trans_q <= 1'b0;
            end
            // Switch reference only once the select pin has settled
            if (frame_rise && !trans_any && state_q != state_auto_hold) begin
                ref_sel_q <= sel_q;
            end
        end
    end

    // Frequency select latched at reset release only
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            freq_q <= 2'h0;
        end else if (!sel_seen_q) begin
            freq_q <= {i_ref_freq_pick_hi, i_ref_freq_pick_lo};
        end
    end

    // Reference falling edge detection
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ref_a_q <= 1'b0;
            ref_b_q <= 1'b0;
            fall_q  <= 1'b0;
        end else begin
            ref_a_q <= i_ref_in_a;
            ref_b_q <= i_ref_in_b;
            fall_q  <= prev_ref & ~cur_ref & (state_q != state_freerun);
        end
    end

    // Holdover word storage, two slots alternated every save period
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            save_cnt_q  <= 32'h0;
            slot_q      <= 1'b0;
            slot0_q     <= '0;
            slot1_q     <= '0;
            hold_word_q <= '0;
        end else begin
            if (!in_normal || !i_loop_locked || save_tick) begin
                save_cnt_q <= 32'h0;
            end else begin
                save_cnt_q <= save_cnt_q + 32'h1;
            end
            if (in_normal && i_loop_locked && save_tick) begin
                if (slot_q) begin
                    slot1_q <= i_freq_word;
                end else begin
                    slot0_q <= i_freq_word;
                end
                slot_q <= ~slot_q;
            end
            // Older slot is the one about to be overwritten next
            if (in_normal && state_d != state_normal && state_d != state_freerun) begin
                hold_word_q <= older_word;
            end
        end
    end

    // Off-frequency monitor, refreshed per period
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mon_cnt_q <= 32'h0;
            mon_q     <= 1'b0;
        end else begin
            mon_cnt_q <= mon_tick ? 32'h0 : mon_cnt_q + 32'h1;
            if (mon_tick) begin
                mon_q <= i_ref_off_12ppm;
            end
        end
    end

    // Lock deadline tracking in Normal
    always_ff @(posedge i_clk) begin
        if (i_rst || !in_normal || i_loop_locked) begin
            lock_cnt_q <= 32'h0;
        end else if (lock_cnt_q != lock_limit) begin
            lock_cnt_q <= lock_cnt_q + 32'h1;
        end
    end

    // Outputs
    assign o_normal            = in_normal;
    assign o_hold              = (state_q == state_hold) || (state_q == state_auto_hold)
                                 || (state_q == state_short_hold);
    assign o_freerun           = (state_q == state_freerun);
    assign o_use_master_osc    = o_freerun;
    assign o_phase_step_fix_en = fix_q;
    assign o_quick_lock_active = in_normal & i_quick_lock_req;
    assign o_ref_sel           = ref_sel_q;
    assign o_ref_fall          = fall_q;
    assign o_ref_freq          = freq_q;
    assign o_ref_freq_valid    = (freq_q != 2'(freq_reserved));
    assign o_ref_off_freq_flag = mon_q;
    assign o_hold_word         = hold_word_q;
    assign o_lock_timeout      = in_normal && (lock_cnt_q == lock_limit);
    assign o_state             = state_q;

endmodule

// ---- tb/dpll_ctrl_asserts.sv ----
// Port-level checker for the DPLL mode and state controller
`timescale 1ns/10ps
module dpll_ctrl_asserts
    import dpll_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Watched inputs
    input  wire logic       i_op_state_pick_hi,
    input  wire logic       i_op_state_pick_lo,
    input  wire logic       i_quick_lock_req,
    input  wire logic       i_frame_pulse_8k,
    input  wire logic       i_ref_invalid,
    // Watched outputs
    input  wire logic       o_normal,
    input  wire logic       o_hold,
    input  wire logic       o_freerun,
    input  wire logic       o_phase_step_fix_en,
    input  wire logic       o_quick_lock_active,
    input  wire logic       o_use_master_osc,
    input  wire logic       o_ref_fall,
    input  wire logic [1:0] o_ref_freq,
    input  wire logic       o_ref_freq_valid,
    input  wire logic [2:0] o_state
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire [1:0] pins = {i_op_state_pick_hi, i_op_state_pick_lo};
    sequence frame_rise;
        i_frame_pulse_8k && !$past(i_frame_pulse_8k);
    endsequence
    sequence rise_in(st);
        frame_rise ##0 (o_state == st);
    endsequence
    chk_frame_only_change: assert property (!$stable(o_state) |->
        $past(i_frame_pulse_8k) && !$past(i_frame_pulse_8k, 2))
        else $error("state changed without a frame rise");
    chk_mode_to_normal: assert property (rise_in(state_freerun) ##0 pins == MODE_NORMAL
        |=> o_state == state_normal) else $error("normal code not taken");
    chk_reserved_keeps: assert property (rise_in(state_freerun) ##0 pins == MODE_RESERVED
        |=> $stable(o_state)) else $error("reserved code changed state");
    chk_auto_hold_entry: assert property (rise_in(state_normal) ##0 i_ref_invalid
        |=> o_state == state_auto_hold) else $error("invalid reference ignored");
    chk_fix_drop: assert property (!$stable(o_state) && o_state != state_normal
        |-> !o_phase_step_fix_en) else $error("correction kept on state change");
    chk_normal_flag: assert property (o_normal == (o_state == state_normal))
        else $error("normal status wrong");
    chk_hold_flag: assert property (o_hold == (o_state inside
        {state_hold, state_auto_hold, state_short_hold})) else $error("hold status wrong");
    chk_freerun_osc: assert property ((o_freerun == (o_state == state_freerun)) &&
        (o_use_master_osc == o_freerun)) else $error("freerun status wrong");
    chk_quick_gate: assert property (o_quick_lock_active ==
        (o_normal && i_quick_lock_req)) else $error("quick lock gating wrong");
    chk_fall_pulse: assert property (o_ref_fall |=> !o_ref_fall)
        else $error("reference edge pulse too long");
    chk_freq_valid: assert property (o_ref_freq_valid == (o_ref_freq != 2'h0))
        else $error("frequency valid wrong");
endmodule

bind dpll_mode_state_control dpll_ctrl_asserts chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_op_state_pick_hi(i_op_state_pick_hi), .i_op_state_pick_lo(i_op_state_pick_lo),
    .i_quick_lock_req(i_quick_lock_req), .i_frame_pulse_8k(i_frame_pulse_8k),
    .i_ref_invalid(i_ref_invalid), .o_normal(o_normal), .o_hold(o_hold),
    .o_freerun(o_freerun), .o_phase_step_fix_en(o_phase_step_fix_en),
    .o_quick_lock_active(o_quick_lock_active), .o_use_master_osc(o_use_master_osc),
    .o_ref_fall(o_ref_fall), .o_ref_freq(o_ref_freq), .o_ref_freq_valid(o_ref_freq_valid),
    .o_state(o_state));

// ---- tb/board_ctrl_model.sv ----
// Board control logic model: mode and select pins, frame pulse, references
`timescale 1ns/10ps
module board_ctrl_model
    import dpll_ctrl_pkg::*;
#(
    parameter int FRAME_CYC = 20
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Requests from the bench
    input  wire logic [1:0] i_mode_req,
    input  wire logic       i_sel_req,
    // Pins toward the controller
    output logic [1:0]      o_mode,
    output logic            o_sel,
    output logic            o_frame,
    output logic            o_ref_a,
    output logic            o_ref_b
);
    logic [7:0] cnt_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q  <= 8'h00;
            o_mode <= MODE_FREERUN;
            o_sel  <= 1'b0;
        end else begin
            cnt_q  <= (cnt_q == 8'(FRAME_CYC - 1)) ? 8'h00 : cnt_q + 8'h01;
            o_mode <= i_mode_req;
            o_sel  <= i_sel_req;
        end
    end
    // Short high pulse so each frame gives exactly one rise
    assign o_frame = (cnt_q < 8'h02);
    assign o_ref_a = cnt_q[1];
    assign o_ref_b = ~cnt_q[1];
endmodule

// ---- tb/dpll_mode_state_control_test.sv ----
// Self-checking bench for the DPLL mode and state controller
`timescale 1ns/10ps
module dpll_mode_state_control_test;
    import dpll_ctrl_pkg::*;
    logic i_clk = 1'b0, i_rst = 1'b1, sel_req = 1'b0, inv = 1'b0, frame_d = 1'b0;
    logic fix_on = 1'b0, quick = 1'b0, fhi = 1'b0, flo = 1'b0, off = 1'b0, locked = 1'b0;
    logic [1:0] mode_req = MODE_FREERUN, mode, fp, o_ref_freq;
    logic [31:0] word = 32'h0, o_hold_word;
    logic sel, frame, ref_a, ref_b, o_normal, o_hold, o_freerun, o_fix_en, o_quick;
    logic o_osc, o_ref_sel, o_ref_fall, o_freq_valid, o_flag, o_timeout;
    logic [2:0] o_state, prev_state;
    op_state_type exp_q[$], exp_s;
    int error_cnt = 0, cmp_count = 0;
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) frame_d <= frame;
    always @(posedge i_clk) word <= $urandom;
    board_ctrl_model #(.FRAME_CYC(20)) board (.i_clk(i_clk), .i_rst(i_rst),
        .i_mode_req(mode_req), .i_sel_req(sel_req), .o_mode(mode), .o_sel(sel),
        .o_frame(frame), .o_ref_a(ref_a), .o_ref_b(ref_b));
    dpll_mode_state_control #(.SAVE_CYC(8), .MON_CYC(16), .LOCK_CYC(64), .QLOCK_CYC(32)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_op_state_pick_hi(mode[1]),
        .i_op_state_pick_lo(mode[0]), .i_phase_step_fix_on(fix_on), .i_quick_lock_req(quick),
        .i_ref_freq_pick_hi(fhi), .i_ref_freq_pick_lo(flo), .i_ref_select(sel),
        .i_frame_pulse_8k(frame), .i_ref_in_a(ref_a), .i_ref_in_b(ref_b),
        .i_ref_invalid(inv), .i_ref_off_12ppm(off), .i_loop_locked(locked),
        .i_freq_word(word), .o_normal(o_normal), .o_hold(o_hold), .o_freerun(o_freerun),
        .o_phase_step_fix_en(o_fix_en), .o_quick_lock_active(o_quick),
        .o_use_master_osc(o_osc), .o_ref_sel(o_ref_sel), .o_ref_fall(o_ref_fall),
        .o_ref_freq(o_ref_freq), .o_ref_freq_valid(o_freq_valid),
        .o_ref_off_freq_flag(o_flag), .o_hold_word(o_hold_word),
        .o_lock_timeout(o_timeout), .o_state(o_state));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_rise;
        int n;
        n = 0;
        @(posedge i_clk);
        while (!(frame === 1'b1 && frame_d === 1'b0) && n < 100) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 100) chk("frame rise", 1, 0);
    endtask
    // Drive just after a rise so the next rise sees settled pins
    task automatic go(input logic [1:0] m, input logic s, input logic v,
                      input op_state_type e, input bit push);
        wait_rise();
        mode_req <= m;
        sel_req  <= s;
        inv      <= v;
        if (push) exp_q.push_back(e);
        wait_rise();
        repeat (4) @(posedge i_clk);
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // State monitor: every state change consumes the oldest expectation, or is flagged as unexpected when none is queued
    always @(posedge i_clk) begin
        prev_state <= o_state;
        if (!i_rst && o_state !== prev_state) begin
            if (exp_q.size() == 0) chk("unexpected state", 32'h0, 32'(o_state) | 32'h8);
            else begin
                exp_s = exp_q.pop_front();
                chk("state", 32'(exp_s), 32'(o_state));
            end
        end
    end
    initial begin
        #50000;
        chk("watchdog", 0, 1);
        wrap_up();
    end
    initial begin
        void'($urandom(32'hD692));
        fp = 2'($urandom_range(3, 0));
        fhi <= fp[1];
        flo <= fp[0];
        fix_on <= 1'b1;
        locked <= 1'b1;
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk("ref_freq", 32'(fp), 32'(o_ref_freq));
        chk("freq_valid", 32'(fp != 2'h0), 32'(o_freq_valid));
        fhi <= ~fp[1];
        flo <= ~fp[0];
        go(MODE_NORMAL, 1'b0, 1'b0, state_normal, 1);
        chk("fix_en", 1, 32'(o_fix_en));
        go(MODE_NORMAL, 1'b0, 1'b1, state_auto_hold, 1);
        chk("fix_en", 0, 32'(o_fix_en));
        go(MODE_FREERUN, 1'b0, 1'b1, state_auto_hold, 0);
        go(MODE_NORMAL, 1'b0, 1'b0, state_normal, 1);
        chk("fix_en", 1, 32'(o_fix_en));
        go(MODE_NORMAL, 1'b0, 1'b1, state_auto_hold, 1);
        go(MODE_NORMAL, 1'b1, 1'b1, state_short_hold, 1);
        go(MODE_NORMAL, 1'b1, 1'b0, state_normal, 1);
        chk("ref_sel", 1, 32'(o_ref_sel));
        chk("fix_en", 1, 32'(o_fix_en));
        go(MODE_NORMAL, 1'b0, 1'b0, state_short_hold, 1);
        chk("fix_en", 0, 32'(o_fix_en));
        go(MODE_NORMAL, 1'b0, 1'b0, state_normal, 1);
        chk("ref_sel", 0, 32'(o_ref_sel));
        go(MODE_HOLD, 1'b0, 1'b0, state_hold, 1);
        go(MODE_NORMAL, 1'b0, 1'b0, state_normal, 1);
        locked <= 1'b0;
        quick <= 1'b1;
        off <= 1'b1;
        repeat (40) @(posedge i_clk);
        chk("lock_timeout", 1, 32'(o_timeout));
        chk("off_freq_flag", 1, 32'(o_flag));
        off <= 1'b0;
        repeat (40) @(posedge i_clk);
        chk("off_freq_flag", 0, 32'(o_flag));
        go(MODE_FREERUN, 1'b0, 1'b0, state_freerun, 1);
        chk("master_osc", 1, 32'(o_osc));
        go(MODE_RESERVED, 1'b0, 1'b0, state_freerun, 0);
        chk("ref_freq", 32'(fp), 32'(o_ref_freq));
        chk("pending states", 0, 32'(exp_q.size()));
        wrap_up();
    end
endmodule
